// ### include/pattern_link_params.svh
// Constants shared by the pattern command link ends
`ifndef PATTERN_LINK_PARAMS_SVH
`define PATTERN_LINK_PARAMS_SVH
`define OPC_WRITE_ENABLE 8'h06
`define OPC_READ_STATUS 8'h05
`define OPC_PROG_PERSIST 8'h43
`define OPC_WRITE_VOLATILE 8'h4a
`define OPC_READ_PATTERN 8'h41
`define STAT_WIP_BIT 0
`define STAT_WEL_BIT 1
`define EXT_PATTERN_EN_BIT 4
`define EXT_PROG_ERR_BIT 6
`define PATTERN_RESET 8'h00
`define REF_CLK_NS 50
`define SCK_PERIOD_NS 400
`define SCK_HALF_CYC ((`SCK_PERIOD_NS / 2) / `REF_CLK_NS)
`define PROG_TIME_NS 10000
`define PROG_CYC ((`PROG_TIME_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
`define REG_CMD 4'h0
`define REG_STATUS 4'h4
`define REG_IRQ_STAT 4'h8
`define REG_IRQ_MASK 4'hc
`define CMD_CODE_LSB 0
`define CMD_DATA_LSB 8
`define CMD_QPI_BIT 16
`define IRQ_DONE_BIT 0
`define IRQ_REFUSED_BIT 1
`endif

// ### include/pattern_link_pkg.sv
// Types shared by the pattern command link ends
package pattern_link_pkg;
   typedef enum logic [1:0] {
      DEV_IDLE = 2'b01,
      DEV_BUSY = 2'b10
   } dev_state_t;
   typedef enum logic [4:0] {
      HOST_IDLE = 5'b00001,
      HOST_LOW = 5'b00010,
      HOST_HIGH = 5'b00100,
      HOST_END = 5'b01000,
      HOST_GAP = 5'b10000
   } host_state_t;
   typedef enum logic [2:0] {
      CMD_WRITE_ENABLE_CMD = 3'h0,
      CMD_PROG = 3'h1,
      CMD_WVOL = 3'h2,
      CMD_RDPAT = 3'h3,
      CMD_RDSTAT = 3'h4
   } host_cmd_t;
endpackage

// ### include/pattern_link_if.sv
// Serial link between controller and flash pattern logic
`timescale 1ns/10ps
`default_nettype none
interface pattern_link_if;
   logic cs_n;
   logic sck;
   logic [3:0] host_io_out;
   logic [3:0] host_io_oe;
   logic [3:0] dev_io_out;
   logic [3:0] dev_io_oe;
   logic [3:0] io;
   // Resolved data lines, pulled high when nobody drives
   assign io = (dev_io_oe & dev_io_out)
      | (~dev_io_oe & host_io_oe & host_io_out)
      | (~dev_io_oe & ~host_io_oe);
   modport host (output cs_n, output sck, output host_io_out,
      output host_io_oe, input io);
   modport device (input cs_n, input sck, input io,
      output dev_io_out, output dev_io_oe);
endinterface
`default_nettype wire

// ### rtl/pattern_flash_end.sv
// Flash end: pattern register commands over the serial link
// What this block does
// - Persistent program needs write enable latch set
// - Persistent program is 43h plus one byte
// - Chip select must rise after eighth data bit
// - Chip select rise starts self-timed programming
// - Write in progress reads 1 while programming
// - Failed programming sets program error flag
// - Finished programming clears write enable latch
// - Volatile write needs write enable latch set
// - Volatile write is 4Ah plus one byte
// - Volatile write needs rise after eighth data bit
// - Volatile register updates at rise, no busy
// - Opcode 41h shifts volatile pattern out
// - Pattern byte repeats every eight bits (eight single-line or two four-line clocks)
// - Commands work in single and four-line mode
// - Persistent and volatile eight-bit pattern registers
// - Extended read bit 4 follows the pattern output enable input
`timescale 1ns/10ps
`default_nettype none
`include "pattern_link_params.svh"
module pattern_flash_end #(
   parameter int PROG_CYCLES = `PROG_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Link
   pattern_link_if.device link,
   // Mode and fault inputs
   input wire logic qpi_mode_in,
   input wire logic pattern_output_enable_in,
   input wire logic program_fail_in,
   // State outputs
   output logic [7:0] persistent_pattern_out,
   output logic [7:0] volatile_pattern_out,
   output logic [7:0] ext_read_out,
   output logic write_enable_latch_out,
   output logic write_in_progress_out
);
   import pattern_link_pkg::*;

   generate
      if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin : g_bad
         $error("PROG_CYCLES out of range");
      end
   endgenerate

   logic cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d;
   logic [3:0] io_s1, io_s2;
   logic rise, fall, cs_rise, cs_fall;

   // Link inputs pass two flops
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_d <= 1'b1;
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_d <= 1'b0;
         io_s1 <= 4'h0;
         io_s2 <= 4'h0;
      end else begin
         cs_s1 <= link.cs_n;
         cs_s2 <= cs_s1;
         cs_d <= cs_s2;
         sck_s1 <= link.sck;
         sck_s2 <= sck_s1;
         sck_d <= sck_s2;
         io_s1 <= link.io;
         io_s2 <= io_s1;
      end
   end

   assign rise = sck_s2 & ~sck_d & ~cs_s2;
   assign fall = ~sck_s2 & sck_d & ~cs_s2;
   assign cs_rise = cs_s2 & ~cs_d;
   assign cs_fall = ~cs_s2 & cs_d;

   dev_state_t state, next_state;
   logic mode, next_mode;
   logic [5:0] cnt, next_cnt;
   logic [7:0] sh, next_sh, opc, next_opc, osh, next_osh;
   logic [2:0] ocnt, next_ocnt;
   logic [3:0] io_out, next_io_out, io_oe, next_io_oe;
   logic [15:0] timer, next_timer;
   logic [7:0] pend, next_pend, pers, next_pers, vol, next_vol;
   logic [7:0] ext, next_ext;
   logic write_enable_latch, next_wel, write_in_progress, next_wip;
   logic [7:0] src, obyte;
   logic [5:0] step;

   always_comb begin
      next_state = state;
      next_mode = mode;
      next_cnt = cnt;
      next_sh = sh;
      next_opc = opc;
      next_osh = osh;
      next_ocnt = ocnt;
      next_io_out = io_out;
      next_io_oe = io_oe;
      next_timer = timer;
      next_pend = pend;
      next_pers = pers;
      next_vol = vol;
      next_ext = ext;
      next_wel = write_enable_latch;
      next_wip = write_in_progress;
      // one or four bits per clock
      step = mode ? 6'd4 : 6'd1;
      src = 8'h00;
      obyte = 8'h00;
      // enable bit held in extended read
      next_ext[`EXT_PATTERN_EN_BIT] = pattern_output_enable_in;
      if (cs_fall) begin
         next_mode = qpi_mode_in;
         next_cnt = 6'd0;
         next_ocnt = 3'd0;
      end
      if (rise) begin
         next_sh = mode ? {sh[3:0], io_s2} : {sh[6:0], io_s2[0]};
         if (cnt < 6'd32) begin
            next_cnt = cnt + step;
         end
         if (cnt + step == 6'd8) begin
            next_opc = next_sh;
         end
      end
      if (fall && cnt >= 6'd8 &&
         (opc == `OPC_READ_PATTERN || opc == `OPC_READ_STATUS)) begin
         src = (opc == `OPC_READ_PATTERN) ? vol : 8'h00;
         src[`STAT_WIP_BIT] = (opc == `OPC_READ_PATTERN) ?
            vol[`STAT_WIP_BIT] : write_in_progress;
         src[`STAT_WEL_BIT] = (opc == `OPC_READ_PATTERN) ?
            vol[`STAT_WEL_BIT] : write_enable_latch;
         obyte = (ocnt == 3'd0) ? src : osh;
         next_io_oe = mode ? 4'hf : 4'h2;
         next_io_out = mode ? obyte[7:4] : {2'b00, obyte[7], 1'b0};
         next_osh = mode ? {obyte[3:0], 4'h0} : {obyte[6:0], 1'b0};
         next_ocnt = ocnt + (mode ? 3'd4 : 3'd1);
      end
      if (cs_s2) begin
         next_io_oe = 4'h0;
      end
      if (cs_rise && state == DEV_IDLE) begin
         if (opc == `OPC_WRITE_ENABLE && cnt == 6'd8) begin
            next_wel = 1'b1;
         end
         // program needs latch and 16 bits
         if (opc == `OPC_PROG_PERSIST && cnt == 6'd16 && write_enable_latch) begin
            next_state = DEV_BUSY;
            next_timer = 16'(PROG_CYCLES - 1);
            next_pend = sh;
            next_wip = 1'b1;
            next_ext[`EXT_PROG_ERR_BIT] = 1'b0;
         end
         if (opc == `OPC_WRITE_VOLATILE && cnt == 6'd16 && write_enable_latch) begin
            next_vol = sh;
         end
      end
      case (state)
         DEV_IDLE: begin
            next_wip = next_wip;
         end
         DEV_BUSY: begin
            if (timer == 16'd0) begin
               next_state = DEV_IDLE;
               next_wip = 1'b0;
               next_wel = 1'b0;
               if (program_fail_in) begin
                  next_ext[`EXT_PROG_ERR_BIT] = 1'b1;
               end else begin
                  next_pers = pend;
               end
            end else begin
               next_timer = timer - 16'd1;
            end
         end
         default: begin
            next_state = DEV_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= DEV_IDLE;
         mode <= 1'b0;
         cnt <= 6'd0;
         sh <= 8'h00;
         opc <= 8'h00;
         osh <= 8'h00;
         ocnt <= 3'd0;
         io_out <= 4'h0;
         io_oe <= 4'h0;
         timer <= 16'd0;
         pend <= 8'h00;
         pers <= `PATTERN_RESET;
         vol <= `PATTERN_RESET;
         ext <= 8'h00;
         write_enable_latch <= 1'b0;
         write_in_progress <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         cnt <= next_cnt;
         sh <= next_sh;
         opc <= next_opc;
         osh <= next_osh;
         ocnt <= next_ocnt;
         io_out <= next_io_out;
         io_oe <= next_io_oe;
         timer <= next_timer;
         pend <= next_pend;
         pers <= next_pers;
         vol <= next_vol;
         ext <= next_ext;
         write_enable_latch <= next_wel;
         write_in_progress <= next_wip;
      end
   end

   assign link.dev_io_out = io_out;
   assign link.dev_io_oe = io_oe;
   assign persistent_pattern_out = pers;
   // pattern and enable feed the dummy-cycle driver
   assign volatile_pattern_out = vol;
   assign ext_read_out = ext;
   assign write_enable_latch_out = write_enable_latch;
   assign write_in_progress_out = write_in_progress;
endmodule // pattern_flash_end
`default_nettype wire

// ### rtl/pattern_host_end.sv
// Controller end: Avalon-driven pattern command sender
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "pattern_link_params.svh"
module pattern_host_end #(
   parameter int HALF_CYC = `SCK_HALF_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Avalon-MM slave
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Interrupt
   output logic irq_out,
   // Link
   pattern_link_if.host link
);
   import pattern_link_pkg::*;

   generate
      if (HALF_CYC < 3 || HALF_CYC > 255) begin : g_bad
         $error("HALF_CYC out of range");
      end
   endgenerate

   logic [3:0] io_s1, io_s2;
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         io_s1 <= 4'h0;
         io_s2 <= 4'h0;
      end else begin
         io_s1 <= link.io;
         io_s2 <= io_s1;
      end
   end

   host_state_t state, next_state;
   logic [7:0] div, next_div;
   logic [4:0] bitpos, next_bitpos, total, next_total;
   logic [15:0] tx, next_tx;
   logic [7:0] rx, next_rx;
   logic cs_n, next_cs_n, sck, next_sck, rd, next_rd, four_line_instruction_mode, next_qpi;
   logic [3:0] io_oe, next_io_oe, io_out, next_io_out;
   logic waitreq, next_waitreq, irq, next_irq;
   logic [31:0] rdata, next_rdata;
   logic [1:0] stat, next_stat, mask, next_mask, set_ev;
   logic take, half_done;
   logic [7:0] opc;
   logic [4:0] step;
   host_cmd_t cmd;

   always_comb begin
      next_state = state;
      next_div = div;
      next_bitpos = bitpos;
      next_total = total;
      next_tx = tx;
      next_rx = rx;
      next_cs_n = cs_n;
      next_sck = sck;
      next_rd = rd;
      next_qpi = four_line_instruction_mode;
      next_io_oe = io_oe;
      next_waitreq = waitreq;
      next_rdata = rdata;
      next_mask = mask;
      set_ev = 2'b00;
      take = (avs_read_in | avs_write_in) & ~waitreq;
      half_done = (div == 8'(HALF_CYC - 1));
      step = four_line_instruction_mode ? 5'd4 : 5'd1;
      cmd = host_cmd_t'(avs_writedata_in[`CMD_CODE_LSB +: 3]);
      opc = 8'h00;
      // Bus handshake, one wait cycle
      next_waitreq = ~((avs_read_in | avs_write_in) & waitreq);
      if (avs_read_in & waitreq) begin
         case (avs_address_in)
            `REG_STATUS: next_rdata = {15'h0, four_line_instruction_mode, rx, 7'h0,
               state != HOST_IDLE};
            `REG_IRQ_STAT: next_rdata = {30'h0, stat};
            `REG_IRQ_MASK: next_rdata = {30'h0, mask};
            default: next_rdata = 32'h0;
         endcase
      end
      if (take && avs_write_in && avs_address_in == `REG_IRQ_MASK) begin
         next_mask = avs_writedata_in[1:0];
      end
      if (take && avs_write_in && avs_address_in == `REG_CMD) begin
         case (cmd)
            CMD_WRITE_ENABLE_CMD: opc = `OPC_WRITE_ENABLE;
            CMD_PROG: opc = `OPC_PROG_PERSIST;
            CMD_WVOL: opc = `OPC_WRITE_VOLATILE;
            CMD_RDPAT: opc = `OPC_READ_PATTERN;
            CMD_RDSTAT: opc = `OPC_READ_STATUS;
            default: opc = 8'h00;
         endcase
         if (state != HOST_IDLE || opc == 8'h00) begin
            set_ev[`IRQ_REFUSED_BIT] = 1'b1;
         end else begin
            // write enable sent as its own frame
            next_total = (cmd == CMD_WRITE_ENABLE_CMD) ? 5'd8 : 5'd16;
            next_tx = {opc, avs_writedata_in[`CMD_DATA_LSB +: 8]};
            next_rd = (cmd == CMD_RDPAT || cmd == CMD_RDSTAT);
            next_qpi = avs_writedata_in[`CMD_QPI_BIT];
            next_io_oe = next_qpi ? 4'hf : 4'h1;
            next_cs_n = 1'b0;
            next_bitpos = 5'd0;
            next_div = 8'd0;
            next_state = HOST_LOW;
         end
      end
      case (state)
         HOST_IDLE: begin
            next_sck = 1'b0;
         end
         HOST_LOW: begin
            next_div = half_done ? 8'd0 : div + 8'd1;
            if (half_done) begin
               next_sck = 1'b1;
               next_state = HOST_HIGH;
            end
         end
         HOST_HIGH: begin
            next_div = half_done ? 8'd0 : div + 8'd1;
            if (half_done) begin
               next_sck = 1'b0;
               if (rd && bitpos >= 5'd8) begin
                  next_rx = four_line_instruction_mode ? {rx[3:0], io_s2} : {rx[6:0], io_s2[1]};
               end
               next_bitpos = bitpos + step;
               next_tx = four_line_instruction_mode ? {tx[11:0], 4'h0} : {tx[14:0], 1'b0};
               if (rd && next_bitpos == 5'd8) begin
                  next_io_oe = 4'h0;
               end
               // stop exactly after the data byte, or after the opcode for write enable
               next_state = (next_bitpos == total) ? HOST_END : HOST_LOW;
            end
         end
         HOST_END: begin
            next_div = half_done ? 8'd0 : div + 8'd1;
            if (half_done) begin
               next_cs_n = 1'b1;
               next_io_oe = 4'h0;
               next_state = HOST_GAP;
            end
         end
         HOST_GAP: begin
            next_div = half_done ? 8'd0 : div + 8'd1;
            if (half_done) begin
               set_ev[`IRQ_DONE_BIT] = 1'b1;
               next_state = HOST_IDLE;
            end
         end
         default: begin
            next_state = HOST_IDLE;
         end
      endcase
      next_io_out = next_qpi ? next_tx[15:12] : {3'b000, next_tx[15]};
      // Read clears, a new event wins
      next_stat = stat;
      if (take && avs_read_in && avs_address_in == `REG_IRQ_STAT) begin
         next_stat = stat & ~rdata[1:0];
      end
      next_stat = next_stat | set_ev;
      next_irq = |(next_stat & next_mask);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= HOST_IDLE;
         div <= 8'd0;
         bitpos <= 5'd0;
         total <= 5'd0;
         tx <= 16'h0;
         rx <= 8'h00;
         cs_n <= 1'b1;
         sck <= 1'b0;
         rd <= 1'b0;
         four_line_instruction_mode <= 1'b0;
         io_oe <= 4'h0;
         io_out <= 4'h0;
         waitreq <= 1'b1;
         rdata <= 32'h0;
         stat <= 2'b00;
         mask <= 2'b00;
         irq <= 1'b0;
      end else begin
         state <= next_state;
         div <= next_div;
         bitpos <= next_bitpos;
         total <= next_total;
         tx <= next_tx;
         rx <= next_rx;
         cs_n <= next_cs_n;
         sck <= next_sck;
         rd <= next_rd;
         four_line_instruction_mode <= next_qpi;
         io_oe <= next_io_oe;
         io_out <= next_io_out;
         waitreq <= next_waitreq;
         rdata <= next_rdata;
         stat <= next_stat;
         mask <= next_mask;
         irq <= next_irq;
      end
   end

   assign link.cs_n = cs_n;
   assign link.sck = sck;
   assign link.host_io_out = io_out;
   assign link.host_io_oe = io_oe;
   assign avs_readdata_out = rdata;
   assign avs_waitrequest_out = waitreq;
   assign irq_out = irq;
endmodule // pattern_host_end
`default_nettype wire

// ### tb/pattern_link_sva.sv
// Wire-level checks on the pattern command link
`timescale 1ns/10ps
`default_nettype none
`include "pattern_link_params.svh"
module pattern_link_sva (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Link signals
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] host_io_out,
   input wire logic [3:0] host_io_oe,
   input wire logic [3:0] dev_io_out,
   input wire logic [3:0] dev_io_oe,
   input wire logic [3:0] io
);
   logic cs_d;
   logic sck_d;
   logic quad;
   logic done;
   logic [7:0] rises;
   logic [7:0] op;
   wire logic rise_w = sck && !sck_d && !cs_n;
   wire logic q_w = (rises == 8'h00) ? host_io_oe[3] : quad;
   // Frame tracker: clock count, lane width, opcode
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cs_d <= 1'b1;
         sck_d <= 1'b0;
         quad <= 1'b0;
         done <= 1'b0;
         rises <= 8'h00;
         op <= 8'h00;
      end else begin
         cs_d <= cs_n;
         sck_d <= sck;
         if (!cs_n && cs_d) begin
            rises <= 8'h00;
            done <= 1'b0;
         end else if (rise_w) begin
            rises <= rises + 8'h01;
            quad <= q_w;
            if (!done) begin
               op <= q_w ? {op[3:0], io} : {op[6:0], io[0]};
            end
            if (rises == (q_w ? 8'h01 : 8'h07)) begin
               done <= 1'b1;
            end
         end
      end
   end
   default clocking dc @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   AST_SCK_IDLE: assert property (cs_n |-> !sck)
      else $error("Serial clock not low outside frame");
   AST_BYTE_FRAME: assert property ($rose(cs_n) |->
      (quad ? (rises[0] == 1'b0) : (rises[2:0] == 3'h0)))
      else $error("Frame not ended on byte boundary");
   AST_HOST_HOLD: assert property (sck && $past(sck) |->
      $stable(host_io_out) && $stable(host_io_oe))
      else $error("Host data moved while clock high");
   AST_DEV_HOLD: assert property (sck && $past(sck) &&
      (dev_io_oe != 4'h0) |-> $stable(dev_io_out))
      else $error("Device data moved while clock high");
   AST_WRITE_QUIET: assert property (done && (op == `OPC_PROG_PERSIST
      || op == `OPC_WRITE_VOLATILE) |-> dev_io_oe == 4'h0)
      else $error("Device drove lines during write");
   AST_READ_DRIVE: assert property ((dev_io_oe != 4'h0) |-> done &&
      (op == `OPC_READ_PATTERN || op == `OPC_READ_STATUS))
      else $error("Device drove lines outside read data");
   AST_DEV_RELEASE: assert property (cs_n [*6] |-> dev_io_oe == 4'h0)
      else $error("Device kept driving while deselected");
   AST_NO_CLASH: assert property ((dev_io_oe & host_io_oe) == 4'h0)
      else $error("Both ends drive a data line");
   AST_QUAD_OUT: assert property ((dev_io_oe != 4'h0) |->
      dev_io_oe == (quad ? 4'hf : 4'h2))
      else $error("Device output lanes wrong for mode");
   AST_HOST_LANES: assert property (rise_w && !done |->
      host_io_oe == (q_w ? 4'hf : 4'h1))
      else $error("Host opcode lanes wrong for mode");
endmodule // pattern_link_sva
`default_nettype wire

// ### tb/learning_pattern_reg_cmds_tb.sv
// Self-checking bench for the pattern command link
`timescale 1ns/10ps
`default_nettype none
`include "pattern_link_params.svh"
module learning_pattern_reg_cmds_tb;
   import pattern_link_pkg::*;
   logic ref_clk_in;
   logic rst_in;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic four_line_instruction_mode;
   logic pat_en;
   logic prog_fail;
   logic [7:0] pers;
   logic [7:0] vol;
   logic [7:0] ext;
   logic write_enable_latch;
   logic write_in_progress;
   logic [7:0] pers_b;
   logic [7:0] vol_b;
   logic wel_b;
   logic wip_b;
   int bad_count;
   int checked;
   int seed;
   pattern_link_if link();
   pattern_link_if bad_link();
   pattern_host_end pattern_host_end_inst (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .avs_address_in(avs_address),
      .avs_read_in(avs_read), .avs_write_in(avs_write),
      .avs_writedata_in(avs_writedata), .avs_readdata_out(avs_readdata),
      .avs_waitrequest_out(avs_waitrequest), .irq_out(irq), .link(link));
   pattern_flash_end #(.PROG_CYCLES(400)) pattern_flash_end_inst (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(link),
      .qpi_mode_in(four_line_instruction_mode), .pattern_output_enable_in(pat_en),
      .program_fail_in(prog_fail), .persistent_pattern_out(pers),
      .volatile_pattern_out(vol), .ext_read_out(ext),
      .write_enable_latch_out(write_enable_latch), .write_in_progress_out(write_in_progress));
   pattern_flash_end #(.PROG_CYCLES(400)) pattern_flash_end_bad_inst (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(bad_link),
      .qpi_mode_in(1'b0), .pattern_output_enable_in(1'b0),
      .program_fail_in(1'b0), .persistent_pattern_out(pers_b),
      .volatile_pattern_out(vol_b), .ext_read_out(),
      .write_enable_latch_out(wel_b), .write_in_progress_out(wip_b));
   pattern_link_sva pattern_link_sva_inst (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .cs_n(link.cs_n), .sck(link.sck),
      .host_io_out(link.host_io_out), .host_io_oe(link.host_io_oe),
      .dev_io_out(link.dev_io_out), .dev_io_oe(link.dev_io_oe),
      .io(link.io));
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   task automatic conclude;
      $display("Checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a,
         input logic [31:0] d, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge ref_clk_in);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk_in);
   endtask
   task automatic run_cmd(input logic [2:0] c, input logic [7:0] d);
      logic [31:0] q;
      int n;
      bus(1'b1, `REG_CMD, {15'h0, four_line_instruction_mode, d, 5'h00, c}, q);
      n = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 400) begin
         bus(1'b0, `REG_STATUS, 32'h0, q);
         n++;
      end
      if (n >= 400) bad_count++;
   endtask
   // Raw single-line frame sender on the second link
   task automatic bang(input logic [23:0] bits, input int n);
      bad_link.cs_n <= 1'b0;
      bad_link.host_io_oe <= 4'h1;
      for (int i = 0; i < n; i++) begin
         bad_link.host_io_out <= {3'b000, bits[23 - i]};
         repeat (4) @(posedge ref_clk_in);
         bad_link.sck <= 1'b1;
         repeat (4) @(posedge ref_clk_in);
         bad_link.sck <= 1'b0;
      end
      repeat (4) @(posedge ref_clk_in);
      bad_link.cs_n <= 1'b1;
      bad_link.host_io_oe <= 4'h0;
      repeat (12) @(posedge ref_clk_in);
   endtask
   logic [15:0] b_cap;
   always @(posedge bad_link.sck) begin
      b_cap <= {b_cap[14:0], bad_link.io[1]};
   end
   initial begin
      repeat (40000) @(posedge ref_clk_in);
      bad_count++;
      conclude();
   end
   initial begin
      logic [31:0] q;
      logic [7:0] d;
      logic [7:0] p;
      logic [7:0] v;
      int n;
      seed = 1;
      bad_count = 0;
      checked = 0;
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      {four_line_instruction_mode, pat_en, prog_fail} = 3'b000;
      bad_link.cs_n = 1'b1;
      bad_link.sck = 1'b0;
      bad_link.host_io_out = 4'h0;
      bad_link.host_io_oe = 4'h0;
      rst_in = 1'b1;
      repeat (20) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      chk("reset", 32'h0, {pers, vol, 6'h00, write_enable_latch, write_in_progress, 7'h00, irq});
      chk("ext_reset", 32'h0, {24'h0, ext});
      v = 8'h00;
      for (int m = 0; m < 2; m++) begin
         four_line_instruction_mode <= m[0];
         prog_fail <= m[0];
         @(posedge ref_clk_in);
         d = m ? 8'h81 : 8'($random(seed));
         p = 8'($random(seed));
         run_cmd(CMD_WVOL, d);
         chk("vol_locked", {24'h0, v}, {24'h0, vol});
         run_cmd(CMD_WRITE_ENABLE_CMD, 8'h00);
         chk("wel_set", 32'h1, {31'h0, write_enable_latch});
         run_cmd(CMD_WVOL, d);
         v = d;
         chk("vol_written", {24'h0, v}, {24'h0, vol});
         chk("vol_no_busy", 32'h2, {30'h0, write_enable_latch, write_in_progress});
         run_cmd(CMD_RDPAT, 8'h00);
         bus(1'b0, `REG_STATUS, 32'h0, q);
         chk("pattern_read", {24'h0, v}, {24'h0, q[15:8]});
         run_cmd(CMD_PROG, p);
         run_cmd(CMD_RDSTAT, 8'h00);
         bus(1'b0, `REG_STATUS, 32'h0, q);
         chk("status_busy", 32'h3, {24'h0, q[15:8]});
         n = 0;
         while (write_in_progress !== 1'b0 && n < 1000) begin
            @(posedge ref_clk_in);
            n++;
         end
         chk("wip_clear", 32'h0, {31'h0, write_in_progress});
         chk("wel_clear", 32'h0, {31'h0, write_enable_latch});
         chk("prog_err", {31'h0, m[0]}, {31'h0, ext[`EXT_PROG_ERR_BIT]});
         if (m == 0) chk("pers", {24'h0, p}, {24'h0, pers});
         run_cmd(CMD_RDSTAT, 8'h00);
         bus(1'b0, `REG_STATUS, 32'h0, q);
         chk("status_idle", 32'h0, {24'h0, q[15:8]});
         run_cmd(CMD_PROG, ~p);
         chk("no_prog", 32'h0, {31'h0, write_in_progress});
         if (m == 0) chk("pers_kept", {24'h0, p}, {24'h0, pers});
         chk("vol_kept", {24'h0, v}, {24'h0, vol});
      end
      for (int e = 0; e < 2; e++) begin
         pat_en <= e[0];
         repeat (2) @(posedge ref_clk_in);
         chk("pattern_en", {31'h0, e[0]}, {31'h0, ext[4]});
      end
      bus(1'b1, `REG_IRQ_MASK, 32'h1, q);
      chk("irq_up", 32'h1, {31'h0, irq});
      bus(1'b0, `REG_IRQ_STAT, 32'h0, q);
      chk("irq_stat", 32'h1, q);
      chk("irq_down", 32'h0, {31'h0, irq});
      run_cmd(3'h5, 8'h00);
      chk("irq_masked", 32'h0, {31'h0, irq});
      bus(1'b1, `REG_IRQ_MASK, 32'h3, q);
      chk("irq_refused", 32'h1, {31'h0, irq});
      bus(1'b0, `REG_IRQ_STAT, 32'h0, q);
      chk("irq_stat_ref", 32'h2, q);
      bus(1'b0, `REG_IRQ_MASK, 32'h0, q);
      chk("irq_mask", 32'h3, q);
      bus(1'b0, 4'h2, 32'h0, q);
      chk("unmapped", 32'h0, q);
      bus(1'b1, `REG_CMD, {15'h0, four_line_instruction_mode, 8'h00, 5'h00, CMD_RDSTAT}, q);
      run_cmd(CMD_WRITE_ENABLE_CMD, 8'h00);
      chk("busy_write_enable_cmd", 32'h0, {31'h0, write_enable_latch});
      bus(1'b0, `REG_IRQ_STAT, 32'h0, q);
      chk("irq_busy_ref", 32'h3, q);
      bang({`OPC_WRITE_VOLATILE, 8'h5a, 8'h00}, 16);
      chk("b_vol_locked", 32'h0, {24'h0, vol_b});
      bang({`OPC_WRITE_ENABLE, 16'h0000}, 8);
      bang({`OPC_WRITE_VOLATILE, 8'h5a, 8'h00}, 17);
      chk("b_vol_long", 32'h0, {24'h0, vol_b});
      bang({`OPC_PROG_PERSIST, 8'h3c, 8'h00}, 15);
      chk("b_prog_short", 32'h1, {22'h0, pers_b, wip_b, wel_b});
      bang({`OPC_WRITE_VOLATILE, 8'h5a, 8'h00}, 16);
      chk("b_vol_ok", 32'h5a, {24'h0, vol_b});
      bang({`OPC_READ_PATTERN, 16'h0000}, 24);
      chk("b_repeat", 32'h5a5a, {16'h0, b_cap});
      conclude();
   end
endmodule // learning_pattern_reg_cmds_tb
`default_nettype wire
